// ==== verilog/iec_map.svh ====
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH

// ----------------------------------------
// Register word indices (byte address = index * 4)
// ----------------------------------------
`define IEC_IDX_CTRL 4'h0
`define IEC_IDX_EN0 4'h1
`define IEC_IDX_FLG0 4'h6
`define IEC_IDX_STAT 4'hb
`define IEC_GROUPS 5

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define IEC_GIE_BIT 7
`define IEC_PERIPHERAL_GROUP_ENABLE_BIT 6
`define IEC_EDGE_BIT 0
`define IEC_CTRL_RESET 8'h01

// ----------------------------------------
// Implemented enable bits, group 4 down to group 0
// ----------------------------------------
`define IEC_IMPL_MASK {8'h03, 8'hff, 8'h43, 8'hc1, 8'h31}
`define IEC_EXT_BIT 0
`define IEC_VECTOR 16'h0004

`endif

// ==== verilog/iec_pkg.sv ====
package iec_pkg;

	// Five enable or flag registers, one byte each
	typedef logic [4:0][7:0] iec_bank_t;

	// Whole state of the top module
	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_group_enable;
		logic edge_sel;
		iec_bank_t en;
		logic [7:0] rdata;
		logic rdy;
		logic err;
		logic irq;
		logic vload;
		logic [15:0] vaddr;
	} iec_state_t;

	// Whole state of the pending flag bank
	typedef struct packed {
		iec_bank_t flags;
		logic pin_prev;
		logic armed;
	} iec_flag_state_t;

endpackage : iec_pkg

// ==== verilog/iec_flag_if.sv ====
`timescale 1ns/1ps
interface iec_flag_if;
	import iec_pkg::*;
	iec_bank_t flags;
	iec_bank_t clr;
	logic edge_sel;

	modport bank_mp (output flags, input clr, input edge_sel);
	modport ctl_mp (input flags, output clr, output edge_sel);
endinterface : iec_flag_if

// ==== verilog/iec_flag_bank.sv ====
`timescale 1ns/1ps
`include "iec_map.svh"
module iec_flag_bank
	import iec_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire iec_bank_t src_event,
	input wire logic ext_pin,
	iec_flag_if.bank_mp fb
);

	iec_flag_state_t s_reg;
	iec_flag_state_t s_next;
	iec_bank_t set_v;
	logic ext_edge;
	localparam iec_bank_t IMPL = `IEC_IMPL_MASK;
	// Event-driven bits only; the pin flag has its own check
	localparam iec_bank_t EVT = IMPL & 40'hff_ffff_fffe;

	// ----------------------------------------
	// Edge detect on the external pin
	// ----------------------------------------
	// Armed only after one sample, so a pin high at reset is no edge
	assign ext_edge = s_reg.armed && (fb.edge_sel ? (ext_pin && !s_reg.pin_prev)
		: (!ext_pin && s_reg.pin_prev));

	// ----------------------------------------
	// Set terms per group
	// ----------------------------------------
	genvar g;
	for (g = 0; g < `IEC_GROUPS; g++)
	begin : g_grp
		if (g == 0)
		begin : g_core
			// Pin flag comes from the edge detector, not the event input
			assign set_v[g] = (src_event[g] & IMPL[g] & ~8'h01) | {7'h00, ext_edge};
		end
		else
		begin : g_per
			assign set_v[g] = src_event[g] & IMPL[g];
		end
	end

	// Next state: set wins over a clear in the same cycle
	always_comb
	begin
		s_next = s_reg;
		s_next.flags = (s_reg.flags & ~fb.clr) | set_v;
		s_next.pin_prev = ext_pin;
		s_next.armed = 1'b1;
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign fb.flags = s_reg.flags;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_event_sets;
		@(posedge mclk) disable iff (rst)
		((src_event & EVT) != '0) |=> ((s_reg.flags & $past(src_event & EVT)) == $past(src_event & EVT));
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event did not set its flag");

	property p_pin_edge;
		@(posedge mclk) disable iff (rst)
		(s_reg.armed && fb.edge_sel && !s_reg.pin_prev && ext_pin) |=> s_reg.flags[0][`IEC_EXT_BIT];
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("rising pin edge lost");

endmodule : iec_flag_bank

// ==== verilog/iec_top.sv ====
`timescale 1ns/1ps
`include "iec_map.svh"
module iec_top
	import iec_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire iec_bank_t src_event,
	input wire logic ext_pin,
	input wire logic core_ack,
	input wire logic return_from_handler,
	output logic irq_request,
	output logic vector_load,
	output logic [15:0] vector_addr
);

	localparam iec_bank_t IMPL = `IEC_IMPL_MASK;
	localparam logic [7:0] CTRL_RST = `IEC_CTRL_RESET;

	iec_state_t s_reg;
	iec_state_t s_next;
	iec_flag_if fif ();
	iec_bank_t clr_v;
	logic [3:0] idx;
	logic hit;
	logic setup;
	logic access;
	logic wr_ok;
	logic accept;
	logic core_pend;
	logic per_pend;

	// ----------------------------------------
	// Pending flag bank
	// ----------------------------------------
	iec_flag_bank u_flags (
		.mclk(mclk),
		.rst(rst),
		.src_event(src_event),
		.ext_pin(ext_pin),
		.fb(fif.bank_mp)
	);

	assign fif.edge_sel = s_reg.edge_sel;
	assign fif.clr = clr_v;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Word aligned, twelve live words; everything else answers with an error
	assign idx = paddr[5:2];
	assign hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00) && (idx <= `IEC_IDX_STAT);
	assign setup = psel && !penable;
	assign access = psel && penable && s_reg.rdy;
	assign wr_ok = access && pwrite && hit && pstrb[0];
	assign accept = s_reg.irq && core_ack;

	// Flag clear is write-one-to-clear on the flag words
	always_comb
	begin
		clr_v = '0;
		for (int g = 0; g < `IEC_GROUPS; g++)
		begin
			if (wr_ok && (idx == (`IEC_IDX_FLG0 + 4'(g))))
				clr_v[g] = pwdata[7:0] & IMPL[g];
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.rdy = 1'b0;
		s_next.vload = 1'b0;
		s_next.err = 1'b0;
		// Setup cycle: latch read data and the answer for the access phase
		if (setup)
		begin
			s_next.rdy = 1'b1;
			s_next.err = !hit;
			s_next.rdata = 8'h00;
			if (idx == `IEC_IDX_CTRL)
			begin
				s_next.rdata[`IEC_GIE_BIT] = s_reg.global_irq_enable;
				s_next.rdata[`IEC_PERIPHERAL_GROUP_ENABLE_BIT] = s_reg.peripheral_group_enable;
				s_next.rdata[`IEC_EDGE_BIT] = s_reg.edge_sel;
			end
			else if (idx == `IEC_IDX_STAT)
				s_next.rdata = {7'h00, s_reg.irq};
			for (int g = 0; g < `IEC_GROUPS; g++)
			begin
				if (idx == (`IEC_IDX_EN0 + 4'(g)))
					s_next.rdata = s_reg.en[g];
				if (idx == (`IEC_IDX_FLG0 + 4'(g)))
					s_next.rdata = fif.flags[g];
			end
			// Unmapped or misaligned reads return zero
			if (!hit)
				s_next.rdata = 8'h00;
		end
		// Access phase write; unimplemented bits are dropped by the masks
		if (wr_ok && (idx == `IEC_IDX_CTRL))
		begin
			s_next.global_irq_enable = pwdata[`IEC_GIE_BIT];
			s_next.peripheral_group_enable = pwdata[`IEC_PERIPHERAL_GROUP_ENABLE_BIT];
			s_next.edge_sel = pwdata[`IEC_EDGE_BIT];
		end
		for (int g = 0; g < `IEC_GROUPS; g++)
		begin
			if (wr_ok && (idx == (`IEC_IDX_EN0 + 4'(g))))
				s_next.en[g] = pwdata[7:0] & IMPL[g];
		end
		// Handler return re-enables; an accept in the same cycle wins
		if (return_from_handler)
			s_next.global_irq_enable = 1'b1;
		if (accept)
		begin
			s_next.global_irq_enable = 1'b0;
			s_next.vload = 1'b1;
			s_next.vaddr = `IEC_VECTOR;
		end
		// Request follows the new global enable, so it drops with the accept
		s_next.irq = s_next.global_irq_enable && (|(fif.flags[0] & s_next.en[0])
			|| (s_next.peripheral_group_enable && |(fif.flags[4:1] & s_next.en[4:1])));
	end

	// Pending terms against the enables about to take effect
	assign core_pend = |(fif.flags[0] & s_next.en[0]);
	assign per_pend = |(fif.flags[4:1] & s_next.en[4:1]);

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.edge_sel <= CTRL_RST[`IEC_EDGE_BIT];
		end
		else
			s_reg <= s_next;
	end

	assign prdata = {24'h000000, s_reg.rdata};
	assign pready = s_reg.rdy;
	assign pslverr = s_reg.err;
	assign irq_request = s_reg.irq;
	assign vector_load = s_reg.vload;
	assign vector_addr = s_reg.vaddr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_gie_blocks;
		!s_reg.global_irq_enable |-> !irq_request;
	endproperty
	a_gie_blocks: assert property (p_gie_blocks) else $error("request while global enable clear");

	property p_peripheral_group_enable_gate;
		(irq_request && !s_reg.peripheral_group_enable) |-> $past(core_pend);
	endproperty
	a_peripheral_group_enable_gate: assert property (p_peripheral_group_enable_gate) else $error("peripheral request without group enable");

	property p_core_only;
		(s_reg.global_irq_enable && !s_reg.peripheral_group_enable && !return_from_handler && !accept && !psel && !core_pend)
			##1 (s_reg.global_irq_enable && core_pend && !accept && !psel) |=> irq_request;
	endproperty
	a_core_only: assert property (p_core_only) else $error("group zero source did not request");

	sequence s_accept;
		irq_request && core_ack;
	endsequence
	sequence s_vectored;
		!s_reg.global_irq_enable && vector_load && (vector_addr == 16'h0004);
	endsequence
	property p_vector;
		s_accept |=> s_vectored ##1 !vector_load;
	endproperty
	a_vector: assert property (p_vector) else $error("accept did not vector");

	property p_return;
		(return_from_handler && !accept) |=> s_reg.global_irq_enable;
	endproperty
	a_return: assert property (p_return) else $error("return did not re-enable");

	property p_reset_vals;
		disable iff (1'b0) $past(rst) |-> (!s_reg.global_irq_enable && !s_reg.peripheral_group_enable && s_reg.edge_sel && (s_reg.en == '0));
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_unimpl;
		((s_reg.en & ~IMPL) == '0) && (!pready || (prdata[31:8] == 24'h000000));
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit visible");

	property p_apb_answer;
		(psel && !penable) |=> (pready && (pslverr == $past(!hit))) ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

	property p_ctrl_write;
		(wr_ok && (idx == `IEC_IDX_CTRL) && !accept && !return_from_handler)
			|=> (s_reg.peripheral_group_enable == $past(pwdata[6])) && (s_reg.edge_sel == $past(pwdata[0]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	// ----------------------------------------
	// Register and core link checks
	// ----------------------------------------
	property p_gie_write;
		(wr_ok && (idx == `IEC_IDX_CTRL) && !accept && !return_from_handler)
			|=> (s_reg.global_irq_enable == $past(pwdata[7]));
	endproperty
	a_gie_write: assert property (p_gie_write) else $error("global enable write lost");

	// Enable writes keep only the live bits of each group
	property p_en0_write;
		(wr_ok && (idx == `IEC_IDX_EN0)) |=> (s_reg.en[0] == ($past(pwdata[7:0]) & 8'h31));
	endproperty
	a_en0_write: assert property (p_en0_write) else $error("group zero enable write wrong");

	property p_en1_write;
		(wr_ok && (idx == (`IEC_IDX_EN0 + 4'h1))) |=> (s_reg.en[1] == ($past(pwdata[7:0]) & 8'hc1));
	endproperty
	a_en1_write: assert property (p_en1_write) else $error("group one enable write wrong");

	property p_en2_write;
		(wr_ok && (idx == (`IEC_IDX_EN0 + 4'h2))) |=> (s_reg.en[2] == ($past(pwdata[7:0]) & 8'h43));
	endproperty
	a_en2_write: assert property (p_en2_write) else $error("group two enable write wrong");

	property p_en3_write;
		(wr_ok && (idx == (`IEC_IDX_EN0 + 4'h3))) |=> (s_reg.en[3] == ($past(pwdata[7:0]) & 8'hff));
	endproperty
	a_en3_write: assert property (p_en3_write) else $error("group three enable write wrong");

	property p_en4_write;
		(wr_ok && (idx == (`IEC_IDX_EN0 + 4'h4))) |=> (s_reg.en[4] == ($past(pwdata[7:0]) & 8'h03));
	endproperty
	a_en4_write: assert property (p_en4_write) else $error("group four enable write wrong");

	// A late acknowledge after the request has gone must not vector
	property p_ack_refused;
		(core_ack && !irq_request) |=> !vector_load;
	endproperty
	a_ack_refused: assert property (p_ack_refused) else $error("vector without a request");

	property p_vaddr_hold;
		!vector_load |-> $stable(vector_addr);
	endproperty
	a_vaddr_hold: assert property (p_vaddr_hold) else $error("vector address moved without a load");

	property p_status_read;
		(setup && hit && (idx == `IEC_IDX_STAT)) |=> (prdata[7:0] == {7'h00, $past(irq_request)});
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	// Quiet bus, no accept: a pending enabled peripheral must request
	property p_peri_request;
		(s_reg.global_irq_enable && s_reg.peripheral_group_enable && (|(fif.flags[4:1] & s_reg.en[4:1])) && !psel && !accept)
			|=> irq_request;
	endproperty
	a_peri_request: assert property (p_peri_request) else $error("peripheral source did not request");

	property p_err_read;
		(setup && !hit) |=> (pslverr && (prdata[7:0] == 8'h00));
	endproperty
	a_err_read: assert property (p_err_read) else $error("unmapped read not refused");

	property p_strobe_off;
		(access && pwrite && !pstrb[0] && (idx == `IEC_IDX_EN0)) |=> (s_reg.en[0] == $past(s_reg.en[0]));
	endproperty
	a_strobe_off: assert property (p_strobe_off) else $error("write without strobe landed");

endmodule : iec_top

// ==== tb/iec_core_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Core side stand-in: accepts requests, returns from handler
// ----------------------------------------
module iec_core_model
	import iec_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic irq_request,
	input wire logic ack_on,
	input wire logic ret_req,
	output logic core_ack,
	output logic return_from_handler
);
	logic ret_req_reg;

	// Ack is a level; it drops once the request has gone
	always_ff @(posedge mclk)
	begin
		ret_req_reg <= rst ? 1'b0 : ret_req;
		core_ack <= ~rst & ack_on & irq_request;
		// One pulse per rise, so a held request cannot re-arm the enable
		return_from_handler <= ~rst & ret_req & ~ret_req_reg;
	end
endmodule : iec_core_model

// ==== tb/interrupt_enable_control_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module interrupt_enable_control_test
	import iec_pkg::*;
;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam logic [7:0] EN_MASK [5] = '{8'h31, 8'hc1, 8'h43, 8'hff, 8'h03};
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ext_pin = 0;
	logic ack_on = 0, ret_req = 0, core_ack, return_from_handler, pready, pslverr;
	logic irq_request, vector_load;
	logic [11:0] paddr = '0;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] pwdata = '0, prdata;
	logic [15:0] vector_addr;
	iec_bank_t src_event = '0;
	logic [7:0] q;
	logic e;
	int n_errors = 0, num_checks = 0;

	iec_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_event(src_event), .ext_pin(ext_pin), .core_ack(core_ack),
		.return_from_handler(return_from_handler), .irq_request(irq_request),
		.vector_load(vector_load), .vector_addr(vector_addr));
	iec_core_model core (.mclk(mclk), .rst(rst), .irq_request(irq_request), .ack_on(ack_on),
		.ret_req(ret_req), .core_ack(core_ack), .return_from_handler(return_from_handler));

	// ----------------------------------------
	// Clock, watchdog, bus tasks
	// ----------------------------------------
	initial
	begin
		forever #4 mclk = ~mclk;
	end

	// Whole run is under two hundred cycles; this span is far beyond it
	initial
	begin
		#100000;
		n_errors++;
		end_sim();
	end

	task automatic end_sim;
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// Starts just after an edge; idle cycle at the end avoids double drives
	// Waits for the answer as long as it takes; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do
		begin
			@(posedge mclk);
		end
		while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		`CHK(q, x)
	endtask : rd

	task automatic wait_vec;
		int n;
		n = 0;
		while (vector_load !== 1'b1 && n < 20)
		begin
			@(posedge mclk);
			n++;
		end
		`CHK(vector_load, 1'b1)
		`CHK(vector_addr, 16'h0004)
		`CHK(irq_request, 1'b0)
	endtask : wait_vec

	task automatic pulse(input int bitno);
		src_event[bitno/8][bitno%8] <= 1'b1;
		@(posedge mclk);
		src_event <= '0;
		repeat (2) @(posedge mclk);
	endtask : pulse

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		rd(12'h000, 8'h01);
		for (int g = 0; g < 5; g++)
		begin
			rd(12'(12'h004 + 4 * g), 8'h00);
			apb(1'b1, 12'(12'h004 + 4 * g), 8'hff);
			rd(12'(12'h004 + 4 * g), EN_MASK[g]);
			apb(1'b1, 12'(12'h004 + 4 * g), 8'h00);
		end
		apb(1'b1, 12'h000, 8'hff);
		rd(12'h000, 8'hc1);
		apb(1'b0, 12'h030, 8'h00);
		`CHK(e, 1'b1)
		// Flag sets with everything disabled
		apb(1'b1, 12'h000, 8'h01);
		pulse(8);
		rd(12'h01c, 8'h01);
		apb(1'b1, 12'h008, 8'h01);
		apb(1'b1, 12'h000, 8'h81);
		rd(12'h02c, 8'h00);
		`CHK(vector_load, 1'b0)
		ack_on <= 1;
		apb(1'b1, 12'h000, 8'hc1);
		wait_vec();
		rd(12'h000, 8'h41);
		rd(12'h02c, 8'h00);
		apb(1'b1, 12'h01c, 8'hff);
		ret_req <= 1;
		repeat (3) @(posedge mclk);
		ret_req <= 0;
		rd(12'h000, 8'hc1);
		// Group zero source ignores the peripheral-group enable
		apb(1'b1, 12'h000, 8'h81);
		apb(1'b1, 12'h004, 8'h20);
		pulse(5);
		wait_vec();
		ack_on <= 0;
		apb(1'b1, 12'h018, 8'hff);
		// Pin edge select, rising then falling
		apb(1'b1, 12'h000, 8'h01);
		ext_pin <= 1;
		repeat (3) @(posedge mclk);
		rd(12'h018, 8'h01);
		apb(1'b1, 12'h018, 8'hff);
		ext_pin <= 0;
		repeat (3) @(posedge mclk);
		rd(12'h018, 8'h00);
		apb(1'b1, 12'h000, 8'h00);
		ext_pin <= 1;
		repeat (3) @(posedge mclk);
		rd(12'h018, 8'h00);
		ext_pin <= 0;
		repeat (3) @(posedge mclk);
		rd(12'h018, 8'h01);
		// Write without its byte strobe must leave the enable alone
		pstrb <= 4'h0;
		apb(1'b1, 12'h004, 8'h00);
		pstrb <= 4'h1;
		rd(12'h004, 8'h20);
		// Second reset in mid-run
		rst <= 1;
		repeat (2) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		rd(12'h000, 8'h01);
		rd(12'h004, 8'h00);
		rd(12'h018, 8'h00);
		end_sim();
	end
endmodule : interrupt_enable_control_test
